// [rtl/aim_regmap.sv]
`timescale 1ns/1ns
module aim_regmap #(
  parameter int TICK_CYCLES = aim_pkg::WDT_TICK_CYC
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire aim_pkg::aim_req_t req_i,
  output aim_pkg::aim_rsp_t rsp_o,
  input wire logic host_msg_i,
  input wire logic sample_stb_i,
  input wire aim_pkg::aim_words_t eng_value_i,
  input wire aim_pkg::aim_words_t hex_value_i,
  output aim_pkg::aim_cfg_t cfg_o,
  output logic [7:0] range_flag_o,
  output logic wdt_flag_o
);
  typedef struct packed {
    aim_pkg::aim_words_t type_code;
    aim_pkg::aim_words_t value;
    logic [7:0] range_flag;
    logic [15:0] chan_en;
    logic [15:0] station;
    logic [15:0] line_fmt;
    logic [15:0] resp_delay;
    logic [15:0] wdt_timeout;
    logic [15:0] wdt_count;
    logic [15:0] ur_thresh;
    logic protocol_rtu;
    logic filter_50hz;
    logic wdt_enable;
    logic fmt_eng;
    logic wdt_flag;
    logic [7:0] wdt_ticks;
    logic [aim_pkg::TICK_W-1:0] tick_cnt;
    aim_pkg::aim_rsp_t rsp;
  } aim_state_t;

  aim_state_t s_q, s_d;
  logic wdt_expire;
  logic rd_err;
  logic [15:0] rd_data;
  logic wr_err;

  ////////////////////////////////////////////////////////////////////////////
  // read decode
  function automatic logic in_range(input logic [15:0] a, input logic [15:0] base);
    logic [15:0] off;
    off = a - base;
    return off < 16'h0008;
  endfunction

  always_comb begin
    logic [2:0] idx;
    idx = req_i.addr[2:0] - aim_pkg::RANGE_COIL_BASE[2:0];
    rd_err = 1'b0;
    rd_data = 16'h0000;
    case (req_i.space)
      aim_pkg::AIM_COIL: begin
        if (in_range(req_i.addr, aim_pkg::RANGE_COIL_BASE)) begin
          rd_data[0] = s_q.range_flag[idx];
        end else if (req_i.addr == aim_pkg::PROTOCOL_COIL) begin
          rd_data[0] = s_q.protocol_rtu;
        end else if (req_i.addr == aim_pkg::FILTER_COIL) begin
          rd_data[0] = s_q.filter_50hz;
        end else if (req_i.addr == aim_pkg::WDT_EN_COIL) begin
          rd_data[0] = s_q.wdt_enable;
        end else if (req_i.addr == aim_pkg::FORMAT_COIL) begin
          rd_data[0] = s_q.fmt_eng;
        end else if (req_i.addr == aim_pkg::WDT_FLAG_COIL) begin
          rd_data[0] = s_q.wdt_flag;
        end else begin
          rd_err = 1'b1;
        end
      end
      aim_pkg::AIM_DISCRETE: begin
        if (in_range(req_i.addr, aim_pkg::RANGE_INPUT_BASE)) begin
          rd_data[0] = s_q.range_flag[idx];
        end else begin
          rd_err = 1'b1;
        end
      end
      aim_pkg::AIM_INPUT: begin
        if (in_range(req_i.addr, aim_pkg::VALUE_INPUT_BASE)) begin
          rd_data = s_q.value[idx];
        end else begin
          rd_err = 1'b1;
        end
      end
      aim_pkg::AIM_HOLDING: begin
        if (in_range(req_i.addr, aim_pkg::VALUE_HOLD_BASE)) begin
          rd_data = s_q.value[idx];
        end else if (in_range(req_i.addr, aim_pkg::TYPE_BASE)) begin
          rd_data = s_q.type_code[idx];
        end else begin
          case (req_i.addr)
            aim_pkg::FW_LOW: rd_data = aim_pkg::FW_LOW_VAL;
            aim_pkg::FW_HIGH: rd_data = aim_pkg::FW_HIGH_VAL;
            aim_pkg::NAME_LOW: rd_data = aim_pkg::NAME_LOW_VAL;
            aim_pkg::NAME_HIGH: rd_data = aim_pkg::NAME_HIGH_VAL;
            aim_pkg::STATION_REG: rd_data = s_q.station;
            aim_pkg::LINE_FMT_REG: rd_data = s_q.line_fmt;
            aim_pkg::RESP_DELAY_REG: rd_data = s_q.resp_delay;
            aim_pkg::WDT_TIMEOUT_REG: rd_data = s_q.wdt_timeout;
            aim_pkg::CHAN_EN_REG: rd_data = s_q.chan_en;
            aim_pkg::WDT_COUNT_REG: rd_data = s_q.wdt_count;
            aim_pkg::UR_THRESH_REG: rd_data = s_q.ur_thresh;
            default: rd_err = 1'b1;
          endcase
        end
      end
      default: rd_err = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state: writes, watchdog, sampling
  assign wdt_expire = s_q.wdt_enable && !host_msg_i && !req_i.valid && (s_q.wdt_timeout != 16'h0000)
    && (s_q.tick_cnt == aim_pkg::TICK_W'(TICK_CYCLES - 1))
    && ({8'h00, s_q.wdt_ticks} + 16'h0001 >= s_q.wdt_timeout);

  always_comb begin
    logic [2:0] idx;
    logic [15:0] w;
    logic signed [16:0] eng;
    logic signed [16:0] thr;
    logic under;
    logic over;
    s_d = s_q;
    idx = req_i.addr[2:0] - aim_pkg::TYPE_BASE[2:0];
    w = req_i.wdata;
    eng = 17'sh00000;
    thr = $signed({1'b0, 16'(s_q.ur_thresh * aim_pkg::UR_UNIT_UA)});
    under = 1'b0;
    over = 1'b0;
    wr_err = 1'b0;
    // refused writes keep the old value; the master sees err set
    if (req_i.valid && req_i.we) begin
      case (req_i.space)
        aim_pkg::AIM_COIL: begin
          case (req_i.addr)
            aim_pkg::PROTOCOL_COIL: s_d.protocol_rtu = w[0];
            aim_pkg::FILTER_COIL: s_d.filter_50hz = w[0];
            aim_pkg::WDT_EN_COIL: s_d.wdt_enable = w[0];
            aim_pkg::FORMAT_COIL: s_d.fmt_eng = w[0];
            aim_pkg::WDT_FLAG_COIL: s_d.wdt_flag = s_q.wdt_flag && !w[0];
            default: wr_err = 1'b1;
          endcase
        end
        aim_pkg::AIM_HOLDING: begin
          if (in_range(req_i.addr, aim_pkg::TYPE_BASE)) begin
            s_d.type_code[idx] = w;
          end else begin
            case (req_i.addr)
              aim_pkg::STATION_REG:
                if (w >= aim_pkg::STATION_MIN && w <= aim_pkg::STATION_MAX) s_d.station = w;
                else wr_err = 1'b1;
              aim_pkg::LINE_FMT_REG:
                if (w[15:8] == 8'h00 && w[5:0] >= aim_pkg::BAUD_MIN && w[5:0] <= aim_pkg::BAUD_MAX) s_d.line_fmt = w;
                else wr_err = 1'b1;
              aim_pkg::RESP_DELAY_REG:
                if (w <= aim_pkg::RESP_DELAY_MAX) s_d.resp_delay = w;
                else wr_err = 1'b1;
              aim_pkg::WDT_TIMEOUT_REG:
                if (w <= aim_pkg::WDT_TIMEOUT_MAX) s_d.wdt_timeout = w;
                else wr_err = 1'b1;
              aim_pkg::CHAN_EN_REG: s_d.chan_en = w;
              aim_pkg::WDT_COUNT_REG: s_d.wdt_count = w;
              aim_pkg::UR_THRESH_REG:
                if (w <= aim_pkg::UR_THRESH_MAX) s_d.ur_thresh = w;
                else wr_err = 1'b1;
              default: wr_err = 1'b1;
            endcase
          end
        end
        default: wr_err = 1'b1;
      endcase
    end
    // any host traffic restarts the supervision window
    if (!s_q.wdt_enable || host_msg_i || req_i.valid) begin
      s_d.tick_cnt = '0;
      s_d.wdt_ticks = 8'h00;
    end else if (s_q.tick_cnt == aim_pkg::TICK_W'(TICK_CYCLES - 1)) begin
      s_d.tick_cnt = '0;
      s_d.wdt_ticks = s_q.wdt_ticks + 8'h01;
    end else begin
      s_d.tick_cnt = s_q.tick_cnt + aim_pkg::TICK_W'(1);
    end
    // no set in a cycle with a request, so a clear of the same cycle wins
    if (wdt_expire) begin
      s_d.wdt_flag = 1'b1;
      s_d.wdt_count = s_q.wdt_count + 16'h0001;
      s_d.wdt_ticks = 8'h00;
    end
    if (sample_stb_i) begin
      for (int c = 0; c < 8; c++) begin
        eng = $signed({eng_value_i[c][15], eng_value_i[c]});
        case (s_q.type_code[c])
          aim_pkg::TYPE_4_20: under = eng < aim_pkg::ENG_4MA;
          aim_pkg::TYPE_0_20: under = eng < 17'sh00000;
          aim_pkg::TYPE_PM20: under = eng < aim_pkg::ENG_M20MA;
          aim_pkg::TYPE_4_20_UR: under = eng < thr;
          default: under = 1'b0;
        endcase
        case (s_q.type_code[c])
          aim_pkg::TYPE_4_20, aim_pkg::TYPE_0_20, aim_pkg::TYPE_PM20, aim_pkg::TYPE_4_20_UR:
            over = eng > aim_pkg::ENG_20MA;
          default: over = 1'b0;
        endcase
        s_d.range_flag[c] = s_q.chan_en[c] && (under || over);
        if (!s_q.chan_en[c]) begin
          s_d.value[c] = 16'h0000;
        end else if (!s_q.fmt_eng) begin
          s_d.value[c] = hex_value_i[c];
        end else if (under && s_q.type_code[c] == aim_pkg::TYPE_4_20_UR) begin
          s_d.value[c] = 16'h0000;
        end else if (under && s_q.type_code[c] != aim_pkg::TYPE_PM20) begin
          s_d.value[c] = aim_pkg::UNDER_VALUE;
        end else begin
          s_d.value[c] = eng_value_i[c];
        end
      end
    end
    s_d.rsp.valid = req_i.valid;
    s_d.rsp.err = req_i.valid && (req_i.we ? wr_err : rd_err);
    s_d.rsp.rdata = (req_i.valid && !req_i.we) ? rd_data : 16'h0000;
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.type_code <= {8{aim_pkg::TYPE_RST}};
      s_q.chan_en <= aim_pkg::CHAN_EN_RST;
      s_q.station <= aim_pkg::STATION_RST;
      s_q.line_fmt <= aim_pkg::LINE_FMT_RST;
      s_q.resp_delay <= aim_pkg::RESP_DELAY_RST;
      s_q.wdt_timeout <= aim_pkg::WDT_TIMEOUT_RST;
      s_q.ur_thresh <= aim_pkg::UR_THRESH_RST;
      s_q.protocol_rtu <= aim_pkg::PROTOCOL_RST;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign rsp_o = s_q.rsp;
  assign range_flag_o = s_q.range_flag;
  assign wdt_flag_o = s_q.wdt_flag;
  assign cfg_o = '{protocol_rtu: s_q.protocol_rtu, filter_50hz: s_q.filter_50hz, wdt_enable: s_q.wdt_enable,
    fmt_eng: s_q.fmt_eng, chan_en: s_q.chan_en[7:0], station: s_q.station[7:0],
    baud_code: s_q.line_fmt[aim_pkg::BAUD_LSB +: 6], frame_mode: s_q.line_fmt[aim_pkg::FRAME_LSB +: 2],
    resp_delay_ms: s_q.resp_delay[4:0]};

  ////////////////////////////////////////////////////////////////////////////
  // checks
  range_coil_a: assert property (@(posedge clock_i) disable iff (rst_i)
    req_i.valid && !req_i.we && req_i.space == aim_pkg::AIM_COIL && req_i.addr == aim_pkg::RANGE_COIL_BASE
    |=> rsp_o.valid && rsp_o.rdata[0] == $past(s_q.range_flag[0])) else $error("range coil read wrong");
  name_high_a: assert property (@(posedge clock_i) disable iff (rst_i)
    req_i.valid && !req_i.we && req_i.space == aim_pkg::AIM_HOLDING && req_i.addr == aim_pkg::NAME_HIGH
    |=> rsp_o.rdata == aim_pkg::NAME_HIGH_VAL && !rsp_o.err) else $error("module name word wrong");
  bad_baud_a: assert property (@(posedge clock_i) disable iff (rst_i)
    req_i.valid && req_i.we && req_i.space == aim_pkg::AIM_HOLDING && req_i.addr == aim_pkg::LINE_FMT_REG
    && req_i.wdata[5:0] > aim_pkg::BAUD_MAX |=> $stable(cfg_o.baud_code) && rsp_o.err) else $error("bad baud taken");
  chan_en_a: assert property (@(posedge clock_i) disable iff (rst_i)
    req_i.valid && req_i.we && req_i.space == aim_pkg::AIM_HOLDING && req_i.addr == aim_pkg::CHAN_EN_REG
    |=> cfg_o.chan_en == $past(req_i.wdata[7:0])) else $error("channel enable not stored");
  count_clear_a: assert property (@(posedge clock_i) disable iff (rst_i)
    req_i.valid && req_i.we && req_i.space == aim_pkg::AIM_HOLDING && req_i.addr == aim_pkg::WDT_COUNT_REG
    && req_i.wdata == 16'h0000 |=> s_q.wdt_count == 16'h0000) else $error("count not cleared");
  thresh_limit_a: assert property (@(posedge clock_i) disable iff (rst_i)
    req_i.valid && req_i.we && req_i.space == aim_pkg::AIM_HOLDING && req_i.addr == aim_pkg::UR_THRESH_REG
    && req_i.wdata > aim_pkg::UR_THRESH_MAX |=> $stable(s_q.ur_thresh) && rsp_o.err) else $error("threshold over 40");
  protocol_bit_a: assert property (@(posedge clock_i) disable iff (rst_i)
    req_i.valid && req_i.we && req_i.space == aim_pkg::AIM_COIL && req_i.addr == aim_pkg::PROTOCOL_COIL
    |=> cfg_o.protocol_rtu == $past(req_i.wdata[0])) else $error("protocol bit wrong");
  filter_bit_a: assert property (@(posedge clock_i) disable iff (rst_i)
    req_i.valid && req_i.we && req_i.space == aim_pkg::AIM_COIL && req_i.addr == aim_pkg::FILTER_COIL
    |=> cfg_o.filter_50hz == $past(req_i.wdata[0])) else $error("filter bit wrong");
  wdt_off_a: assert property (@(posedge clock_i) disable iff (rst_i)
    !s_q.wdt_enable |-> !wdt_expire ##1 s_q.tick_cnt == '0) else $error("watchdog runs while off");
  hex_format_a: assert property (@(posedge clock_i) disable iff (rst_i)
    sample_stb_i && !s_q.fmt_eng && s_q.chan_en[1] |=> s_q.value[1] == $past(hex_value_i[1]))
    else $error("hex value not used");
  flag_set_a: assert property (@(posedge clock_i) disable iff (rst_i)
    wdt_expire |=> wdt_flag_o ##1 (wdt_flag_o || $past(req_i.valid && req_i.we)))
    else $error("timeout flag not held");
  type_store_a: assert property (@(posedge clock_i) disable iff (rst_i)
    req_i.valid && req_i.we && req_i.space == aim_pkg::AIM_HOLDING && req_i.addr == aim_pkg::TYPE_BASE + 16'h0003
    |=> s_q.type_code[3] == $past(req_i.wdata)) else $error("type code not stored");
  ur_zero_a: assert property (@(posedge clock_i) disable iff (rst_i)
    sample_stb_i && s_q.fmt_eng && s_q.chan_en[0] && s_q.type_code[0] == aim_pkg::TYPE_4_20_UR
    && $signed({eng_value_i[0][15], eng_value_i[0]}) < $signed({1'b0, 16'(s_q.ur_thresh * aim_pkg::UR_UNIT_UA)})
    |=> s_q.value[0] == 16'h0000 && range_flag_o[0]) else $error("under range value not zero");
  count_inc_a: assert property (@(posedge clock_i) disable iff (rst_i)
    wdt_expire |=> s_q.wdt_count == $past(s_q.wdt_count) + 16'h0001 && s_q.wdt_ticks == 8'h00)
    else $error("timeout not counted");
  mirror_a: assert property (@(posedge clock_i) disable iff (rst_i)
    req_i.valid && !req_i.we && (req_i.space == aim_pkg::AIM_INPUT && req_i.addr == aim_pkg::VALUE_INPUT_BASE
    || req_i.space == aim_pkg::AIM_HOLDING && req_i.addr == aim_pkg::VALUE_HOLD_BASE)
    |=> rsp_o.rdata == $past(s_q.value[0])) else $error("mirrored value differs");
endmodule // aim_regmap

// [rtl/aim_pkg.sv]
package aim_pkg;
  typedef enum logic [1:0] {AIM_COIL, AIM_DISCRETE, AIM_INPUT, AIM_HOLDING} aim_space_t;
  typedef logic [7:0][15:0] aim_words_t;
  typedef struct packed {
    logic valid;
    logic we;
    aim_space_t space;
    logic [15:0] addr;
    logic [15:0] wdata;
  } aim_req_t;
  typedef struct packed {
    logic valid;
    logic err;
    logic [15:0] rdata;
  } aim_rsp_t;
  typedef struct packed {
    logic protocol_rtu;
    logic filter_50hz;
    logic wdt_enable;
    logic fmt_eng;
    logic [7:0] chan_en;
    logic [7:0] station;
    logic [5:0] baud_code;
    logic [1:0] frame_mode;
    logic [4:0] resp_delay_ms;
  } aim_cfg_t;
  // offsets, as printed point numbers
  localparam logic [15:0] RANGE_COIL_BASE = 16'h0081;
  localparam logic [15:0] PROTOCOL_COIL = 16'h0101;
  localparam logic [15:0] FILTER_COIL = 16'h0103;
  localparam logic [15:0] WDT_EN_COIL = 16'h0105;
  localparam logic [15:0] FORMAT_COIL = 16'h010D;
  localparam logic [15:0] WDT_FLAG_COIL = 16'h010E;
  localparam logic [15:0] RANGE_INPUT_BASE = 16'h2791;
  localparam logic [15:0] VALUE_INPUT_BASE = 16'h7531;
  localparam logic [15:0] VALUE_HOLD_BASE = 16'h9C41;
  localparam logic [15:0] TYPE_BASE = 16'h9D41;
  localparam logic [15:0] FW_LOW = 16'h9E21;
  localparam logic [15:0] FW_HIGH = 16'h9E22;
  localparam logic [15:0] NAME_LOW = 16'h9E23;
  localparam logic [15:0] NAME_HIGH = 16'h9E24;
  localparam logic [15:0] STATION_REG = 16'h9E25;
  localparam logic [15:0] LINE_FMT_REG = 16'h9E26;
  localparam logic [15:0] RESP_DELAY_REG = 16'h9E28;
  localparam logic [15:0] WDT_TIMEOUT_REG = 16'h9E29;
  localparam logic [15:0] CHAN_EN_REG = 16'h9E2A;
  localparam logic [15:0] WDT_COUNT_REG = 16'h9E2C;
  localparam logic [15:0] UR_THRESH_REG = 16'h9E2E;
  // identity words: arbitrary values
  localparam logic [15:0] FW_LOW_VAL = 16'h0001;
  localparam logic [15:0] FW_HIGH_VAL = 16'h0000;
  localparam logic [15:0] NAME_LOW_VAL = 16'hA5A5;
  localparam logic [15:0] NAME_HIGH_VAL = 16'h5A5A;
  // field layout and limits
  localparam int BAUD_LSB = 0;
  localparam int FRAME_LSB = 6;
  localparam logic [5:0] BAUD_MIN = 6'h03;
  localparam logic [5:0] BAUD_MAX = 6'h0A;
  localparam logic [15:0] STATION_MIN = 16'h0001;
  localparam logic [15:0] STATION_MAX = 16'h00F7;
  localparam logic [15:0] RESP_DELAY_MAX = 16'h001E;
  localparam logic [15:0] WDT_TIMEOUT_MAX = 16'h00FF;
  localparam logic [15:0] UR_THRESH_MAX = 16'h0028;
  localparam logic [15:0] UR_UNIT_UA = 16'h0064;
  // type codes and engineering limits
  localparam logic [15:0] TYPE_4_20 = 16'h0007;
  localparam logic [15:0] TYPE_PM20 = 16'h000D;
  localparam logic [15:0] TYPE_0_20 = 16'h001A;
  localparam logic [15:0] TYPE_4_20_UR = 16'h001D;
  localparam logic signed [16:0] ENG_4MA = 17'sh00FA0;
  localparam logic signed [16:0] ENG_20MA = 17'sh04E20;
  localparam logic signed [16:0] ENG_M20MA = -17'sh04E20;
  localparam logic [15:0] UNDER_VALUE = 16'h8000;
  // reset values
  localparam logic [15:0] TYPE_RST = 16'h0008;
  localparam logic [15:0] CHAN_EN_RST = 16'h00FF;
  localparam logic [15:0] STATION_RST = 16'h0001;
  localparam logic [15:0] LINE_FMT_RST = 16'h0006;
  localparam logic [15:0] RESP_DELAY_RST = 16'h0000;
  localparam logic [15:0] WDT_TIMEOUT_RST = 16'h0000;
  localparam logic [15:0] UR_THRESH_RST = 16'h0028;
  localparam logic PROTOCOL_RST = 1'b1;
  // watchdog tick, 0.1 s
  localparam int CLK_HZ = 20000000;
  localparam int WDT_TICK_MS = 100;
  localparam int WDT_TICK_CYC = WDT_TICK_MS * (CLK_HZ / 1000);
  localparam int TICK_W = 21;
endpackage

// [dv/aim_host_model.sv]
`timescale 1ns/1ns
module aim_host_model (
  input wire logic clock_i,
  output aim_pkg::aim_req_t req_o,
  input wire aim_pkg::aim_rsp_t rsp_i
);
  initial req_o = '0;
  ////////////////////////////////////////////////////////////////////////////////
  // one request per call; the answer is taken at the falling edge after the taking edge
  task automatic xfer(input logic we, input aim_pkg::aim_space_t sp, input logic [15:0] a,
                      input logic [15:0] wd, output logic [15:0] rd, output logic er);
    @(negedge clock_i);
    req_o <= '{valid: 1'b1, we: we, space: sp, addr: a, wdata: wd};
    @(negedge clock_i);
    // released lines other than space show inverted junk, never the last request
    req_o <= '{valid: 1'b0, we: ~we, space: sp, addr: ~a, wdata: ~wd};
    rd = rsp_i.rdata;
    er = rsp_i.valid ? rsp_i.err : 1'bx;
  endtask
  task automatic clear_flag(output logic er);
    logic [15:0] rd;
    xfer(1'b1, aim_pkg::AIM_COIL, aim_pkg::WDT_FLAG_COIL, 16'h0001, rd, er);
  endtask
endmodule // aim_host_model

// [dv/test_analog_input_modbus_register_map.sv]
`timescale 1ns/1ns
module test_analog_input_modbus_register_map;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic host_msg_i = 1'b0;
  logic sample_stb_i = 1'b0;
  aim_pkg::aim_words_t eng_value_i = '0;
  aim_pkg::aim_words_t hex_value_i = '0;
  aim_pkg::aim_req_t req;
  aim_pkg::aim_rsp_t rsp;
  aim_pkg::aim_cfg_t cfg;
  logic [7:0] range_flag;
  logic wdt_flag;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [15:0] rd, v, lf, thr, a;
  logic er, b;
  int n;
  always #25 clock_i = ~clock_i;
  aim_host_model aim_host_model_inst (.clock_i(clock_i), .req_o(req), .rsp_i(rsp));
  aim_regmap #(.TICK_CYCLES(4)) aim_regmap_inst (.clock_i(clock_i), .rst_i(rst_i), .req_i(req), .rsp_o(rsp),
    .host_msg_i(host_msg_i), .sample_stb_i(sample_stb_i), .eng_value_i(eng_value_i),
    .hex_value_i(hex_value_i), .cfg_o(cfg), .range_flag_o(range_flag), .wdt_flag_o(wdt_flag));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic fmt_bad(input logic [15:0] f);
    return (f[15:8] != 8'h00) || (f[5:0] < 6'h03) || (f[5:0] > 6'h0A);
  endfunction
  // under-range current input on the detecting type reads as zero
  function automatic logic [15:0] eng_exp(input logic [15:0] ty, input logic [15:0] th, input logic [15:0] e);
    return (ty == aim_pkg::TYPE_4_20_UR && $signed(e) < $signed(th * 16'h0064)) ? 16'h0000 : e;
  endfunction
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] ad, input logic [15:0] wd, input logic e,
                    input aim_pkg::aim_space_t sp = aim_pkg::AIM_HOLDING);
    aim_host_model_inst.xfer(1'b1, sp, ad, wd, rd, er);
    chk("write refusal", e, er);
  endtask
  task automatic rdc(input logic [15:0] ad, input logic [15:0] exp, input string what,
                     input aim_pkg::aim_space_t sp = aim_pkg::AIM_HOLDING);
    aim_host_model_inst.xfer(1'b0, sp, ad, 16'h0000, rd, er);
    chk(what, 16'h0000, er);
    chk(what, exp, rd);
  endtask
  task automatic strobe();
    @(negedge clock_i);
    sample_stb_i = 1'b1;
    @(negedge clock_i);
    sample_stb_i = 1'b0;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // whole sequence needs well under a thousand cycles
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h16D4));
    repeat (16) @(negedge clock_i);
    rst_i = 1'b0;
    rdc(aim_pkg::LINE_FMT_REG, aim_pkg::LINE_FMT_RST, "line format");
    rdc(aim_pkg::CHAN_EN_REG, aim_pkg::CHAN_EN_RST, "chan enable");
    rdc(aim_pkg::UR_THRESH_REG, aim_pkg::UR_THRESH_RST, "threshold");
    rdc(aim_pkg::WDT_COUNT_REG, 16'h0000, "wdt count");
    rdc(aim_pkg::PROTOCOL_COIL, 16'h0001, "protocol", aim_pkg::AIM_COIL);
    for (int i = 0; i < 8; i++) rdc(aim_pkg::TYPE_BASE + 16'(i), aim_pkg::TYPE_RST, "type");
    rdc(aim_pkg::NAME_LOW, aim_pkg::NAME_LOW_VAL, "name low");
    rdc(aim_pkg::NAME_HIGH, aim_pkg::NAME_HIGH_VAL, "name high");
    wr(aim_pkg::NAME_HIGH, 16'h1234, 1'b1);
    wr(aim_pkg::RANGE_INPUT_BASE, 16'h0001, 1'b1, aim_pkg::AIM_DISCRETE);
    wr(aim_pkg::RANGE_COIL_BASE, 16'h0001, 1'b1, aim_pkg::AIM_COIL);
    wr(16'h9E27, 16'h0000, 1'b1);
    lf = aim_pkg::LINE_FMT_RST;
    for (int i = 0; i < 20; i++) begin
      v = 16'($urandom);
      v[15:8] = (i % 5 == 4) ? 8'h01 : 8'h00;
      v[5:0] = 6'(i % 10 + 2);
      wr(aim_pkg::LINE_FMT_REG, v, fmt_bad(v));
      if (!fmt_bad(v)) lf = v;
      chk("baud", {10'h000, lf[5:0]}, {10'h000, cfg.baud_code});
      chk("frame", {14'h0000, lf[7:6]}, {14'h0000, cfg.frame_mode});
    end
    rdc(aim_pkg::LINE_FMT_REG, lf, "line format");
    wr(aim_pkg::UR_THRESH_REG, 16'h0029, 1'b1);
    wr(aim_pkg::UR_THRESH_REG, 16'h0000, 1'b0);
    thr = 16'($urandom_range(40, 1));
    wr(aim_pkg::UR_THRESH_REG, thr, 1'b0);
    rdc(aim_pkg::UR_THRESH_REG, thr, "threshold");
    v = 16'($urandom);
    wr(aim_pkg::CHAN_EN_REG, {8'h00, v[7:0]}, 1'b0);
    chk("cfg chan", {8'h00, v[7:0]}, {8'h00, cfg.chan_en});
    rdc(aim_pkg::CHAN_EN_REG, {8'h00, v[7:0]}, "chan enable");
    wr(aim_pkg::CHAN_EN_REG, 16'h00FF, 1'b0);
    // station, reply delay and timeout limits; refused values must leave cfg alone
    wr(aim_pkg::STATION_REG, 16'h0000, 1'b1);
    wr(aim_pkg::STATION_REG, 16'h00F8, 1'b1);
    wr(aim_pkg::RESP_DELAY_REG, 16'h001F, 1'b1);
    wr(aim_pkg::WDT_TIMEOUT_REG, 16'h0100, 1'b1);
    chk("cfg station", aim_pkg::STATION_RST, {8'h00, cfg.station});
    v = 16'($urandom_range(247, 1));
    wr(aim_pkg::STATION_REG, v, 1'b0);
    chk("cfg station", v, {8'h00, cfg.station});
    v = 16'($urandom_range(30, 0));
    wr(aim_pkg::RESP_DELAY_REG, v, 1'b0);
    chk("cfg delay", v, {11'h000, cfg.resp_delay_ms});
    rdc(aim_pkg::WDT_TIMEOUT_REG, aim_pkg::WDT_TIMEOUT_RST, "wdt timeout");
    for (int i = 0; i < 4; i++) begin
      a = i == 0 ? aim_pkg::PROTOCOL_COIL : i == 1 ? aim_pkg::FILTER_COIL :
          i == 2 ? aim_pkg::FORMAT_COIL : aim_pkg::WDT_EN_COIL;
      b = 1'($urandom_range(1, 0));
      wr(a, {15'h0000, b}, 1'b0, aim_pkg::AIM_COIL);
      rdc(a, {15'h0000, b}, "coil", aim_pkg::AIM_COIL);
      chk("cfg bit", b, i == 0 ? cfg.protocol_rtu : i == 1 ? cfg.filter_50hz :
          i == 2 ? cfg.fmt_eng : cfg.wdt_enable);
    end
    for (int i = 0; i < 8; i++) begin
      v = 16'($urandom);
      wr(aim_pkg::TYPE_BASE + 16'(i), v, 1'b0);
      rdc(aim_pkg::TYPE_BASE + 16'(i), v, "type");
    end
    wr(aim_pkg::TYPE_BASE, aim_pkg::TYPE_4_20_UR, 1'b0);
    wr(aim_pkg::TYPE_BASE + 16'h0001, 16'h0008, 1'b0);
    wr(aim_pkg::FORMAT_COIL, 16'h0000, 1'b0, aim_pkg::AIM_COIL);
    hex_value_i = {$urandom, $urandom, $urandom, $urandom};
    eng_value_i[0] = thr * 16'h0064 - 16'h0001;
    eng_value_i[1] = 16'($signed($urandom_range(20000, 0)) - 10000);
    strobe();
    rdc(aim_pkg::VALUE_INPUT_BASE + 16'h0001, hex_value_i[1], "hex value", aim_pkg::AIM_INPUT);
    wr(aim_pkg::FORMAT_COIL, 16'h0001, 1'b0, aim_pkg::AIM_COIL);
    strobe();
    for (int i = 0; i < 2; i++) begin
      v = eng_exp(i == 0 ? aim_pkg::TYPE_4_20_UR : 16'h0008, thr, eng_value_i[i]);
      rdc(aim_pkg::VALUE_INPUT_BASE + 16'(i), v, "input value", aim_pkg::AIM_INPUT);
      rdc(aim_pkg::VALUE_HOLD_BASE + 16'(i), v, "holding value");
      rdc(aim_pkg::RANGE_INPUT_BASE + 16'(i), 16'(i == 0), "flag", aim_pkg::AIM_DISCRETE);
      rdc(aim_pkg::RANGE_COIL_BASE + 16'(i), 16'(i == 0), "flag", aim_pkg::AIM_COIL);
    end
    chk("flag pins", 16'h0001, {8'h00, range_flag[1:0]});
    wr(aim_pkg::WDT_TIMEOUT_REG, 16'h0002, 1'b0);
    wr(aim_pkg::WDT_EN_COIL, 16'h0001, 1'b0, aim_pkg::AIM_COIL);
    n = 0;
    while (wdt_flag !== 1'b1 && n < 40) begin
      @(negedge clock_i);
      n++;
    end
    // timeout 2 ticks of 4 cycles each: flag shows after exactly 8 quiet edges
    chk("quiet cycles", 16'h0008, 16'(n));
    wr(aim_pkg::WDT_EN_COIL, 16'h0000, 1'b0, aim_pkg::AIM_COIL);
    rdc(aim_pkg::WDT_FLAG_COIL, 16'h0001, "wdt flag", aim_pkg::AIM_COIL);
    rdc(aim_pkg::WDT_COUNT_REG, 16'h0001, "wdt count");
    aim_host_model_inst.clear_flag(er);
    chk("flag clear", 16'h0000, {15'h0000, er});
    rdc(aim_pkg::WDT_FLAG_COIL, 16'h0000, "wdt flag", aim_pkg::AIM_COIL);
    wr(aim_pkg::WDT_COUNT_REG, 16'h0000, 1'b0);
    rdc(aim_pkg::WDT_COUNT_REG, 16'h0000, "wdt count");
    summarize();
  end
endmodule // test_analog_input_modbus_register_map
